//--- hw/spi_eeprom_write_protect_ctrl.sv
`timescale 1ns/10ps
`include "eeprom_wp_defs.svh"
// Contract
// - latch sets on chip select rise after eight bits
// - no latch set if write follows unframed
// - write: opcode, 16-bit address, data bytes
// - up to 32 bytes buffered per write
// - data past page end wraps within page
// - write starts only on byte-aligned select rise
// - latch clears when internal write ends
// - array commands ignored while busy
// - status readable at any time
// - set and clear commands drive latch
// - latch cleared at reset and after writes
// - status byte bit layout fixed
// - busy flag reads one during write
// - latch flag mirrors latch, ignores protection
// - block-protect bits block protected array writes
// - block-protect code to address range decode
// - protect-pin enable gates the pin
// - pin protection blocks only status writes
// - power-on standby, needs falling select first
// - opcode values fixed
// - msb first, sampled on rising clock
// - pin change does not affect running write

////////////////////////////////////////////////////////////////////////////////
// serial link side, clocked by the host serial clock

module spi_eeprom_link
  import eeprom_wp_pkg::*;
(
  input wire logic sck,
  input wire logic rst,
  input wire logic csN,
  input wire logic si,
  input wire logic [7:0] statusBits,
  output link_out_t linkOut
);

  link_shift_t s, next_s;
  link_out_t o, next_o;
  logic soBit;

  always_comb begin
    next_s = s;
    next_s.shift = {s.shift[5:0], si};
    next_s.bitCnt = s.bitCnt + 3'h1;
  end

  // shift state ends with the frame
  always_ff @(posedge sck or posedge csN or posedge rst) begin
    if (csN || rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  always_comb begin
    next_o = o;
    next_o.so = 1'h0;
    next_o.partial = (next_s.bitCnt != 3'h0);
    if (s.bitCnt == 3'h7) begin
      next_o.byteData = {s.shift, si};
      next_o.byteTgl = ~o.byteTgl;
    end
  end

  // toggle starts level with its copy on the system side
  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      o <= '0;
    end else begin
      o <= next_o;
    end
  end

  // status bits out after falling clock, msb first
  always_ff @(negedge sck or posedge csN or posedge rst) begin
    if (csN || rst) begin
      soBit <= 1'h0;
    end else begin
      soBit <= statusBits[3'h7 - s.bitCnt];
    end
  end

  always_comb begin
    linkOut = o;
    linkOut.so = soBit;
  end

endmodule // spi_eeprom_link

////////////////////////////////////////////////////////////////////////////////
// control side, clocked by the system clock

module spi_eeprom_write_protect_ctrl
  import eeprom_wp_pkg::*;
#(
  parameter int WR_CYCLES = `WRITE_CYCLES
)(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic sck,
  input wire logic csN,
  input wire logic si,
  input wire logic wpN,
  output logic so,
  output logic soOe,
  output array_wr_t arrWr,
  output logic [7:0] statusReg
);

  ctrl_state_t s, next_s;
  link_out_t linkOut;

  function automatic logic isProtected(input logic [11:0] a,
                                       input logic [1:0] bp);
    case (bp)
      2'h0: isProtected = 1'h0;
      2'h1: isProtected = (a >= `PROT_QUARTER_BASE);
      2'h2: isProtected = (a >= `PROT_HALF_BASE);
      default: isProtected = 1'h1;
    endcase
  endfunction

  spi_eeprom_link u_link (
    .sck(sck),
    .rst(rst),
    .csN(csN),
    .si(si),
    .statusBits(s.statusOut),
    .linkOut(linkOut)
  );

  logic csFall, csRise, byteEv, aligned, pinProtect, lastCycle;
  assign csFall = s.csnQ & ~s.csnS2;
  assign csRise = ~s.csnQ & s.csnS2;
  assign byteEv = (s.tglS2 ^ s.tglQ) & s.armed & ~s.csnS2;
  assign aligned = ~s.partS2;
  assign pinProtect = s.protectPinEn & ~s.wpS2;
  assign lastCycle = s.busy && (s.busyCnt == 32'(WR_CYCLES - 1));

  always_comb begin
    logic [4:0] idx;
    logic [11:0] wa;
    idx = '0;
    wa = '0;
    next_s = s;
    next_s.csnS1 = csN;
    next_s.csnS2 = s.csnS1;
    next_s.csnQ = s.csnS2;
    next_s.tglS1 = linkOut.byteTgl;
    next_s.tglS2 = s.tglS1;
    next_s.tglQ = s.tglS2;
    next_s.partS1 = linkOut.partial;
    next_s.partS2 = s.partS1;
    next_s.wpS1 = wpN;
    next_s.wpS2 = s.wpS1;
    next_s.arrWr.en = 1'h0;

    // frame start
    if (csFall) begin
      next_s.armed = 1'h1;
      next_s.phase = PH_OPCODE;
      next_s.opcode = 8'h00;
      next_s.nBytes = 6'h00;
      next_s.hasData = 1'h0;
      if (!s.busy) begin
        next_s.pageValid = '0;
      end
    end

    // byte received
    if (byteEv) begin
      if (s.nBytes != 6'h3F) begin
        next_s.nBytes = s.nBytes + 6'h01;
      end
      case (s.phase)
        PH_OPCODE: begin
          next_s.opcode = linkOut.byteData;
          if (linkOut.byteData == `OP_READ_STATUS) begin
            next_s.phase = PH_READ_STATUS;
            next_s.soOe = 1'h1;
          end else if (s.busy) begin
            next_s.phase = PH_IGNORE;
          end else if (linkOut.byteData == `OP_ARRAY_WRITE) begin
            next_s.phase = PH_ADDR_HI;
          end else if (linkOut.byteData == `OP_WRITE_STATUS) begin
            next_s.phase = PH_STATUS_DATA;
          end else begin
            next_s.phase = PH_IGNORE;
          end
        end
        PH_ADDR_HI: begin
          next_s.addr[11:8] = linkOut.byteData[3:0];
          next_s.phase = PH_ADDR_LO;
        end
        PH_ADDR_LO: begin
          next_s.addr[7:0] = linkOut.byteData;
          next_s.phase = PH_DATA;
        end
        PH_DATA: begin
          next_s.pageBuf[s.addr[4:0]] = linkOut.byteData;
          next_s.pageValid[s.addr[4:0]] = 1'h1;
          next_s.addr[4:0] = s.addr[4:0] + 5'h01;
          next_s.hasData = 1'h1;
        end
        PH_STATUS_DATA: begin
          next_s.statusData = linkOut.byteData;
          next_s.hasData = 1'h1;
          next_s.phase = PH_IGNORE;
        end
        default: begin
          next_s.phase = s.phase;
        end
      endcase
    end

    // frame end
    if (csRise) begin
      next_s.soOe = 1'h0;
      next_s.phase = PH_IDLE;
      if (s.armed && !s.busy && aligned) begin
        if (s.opcode == `OP_SET_LATCH && s.nBytes == 6'h01) begin
          next_s.latch = 1'h1;
        end
        if (s.opcode == `OP_CLEAR_LATCH && s.nBytes == 6'h01) begin
          next_s.latch = 1'h0;
        end
        if (s.phase == PH_DATA && s.hasData && s.latch) begin
          next_s.busy = 1'h1;
          next_s.busyArray = 1'h1;
          next_s.busyCnt = '0;
          next_s.pageBase = s.addr[11:5];
        end
        if (s.opcode == `OP_WRITE_STATUS && s.hasData && s.latch
            && !pinProtect) begin
          next_s.busy = 1'h1;
          next_s.busyArray = 1'h0;
          next_s.busyCnt = '0;
          next_s.protectPinEn = s.statusData[`ST_PROTECT_PIN_EN];
          next_s.blockProtect =
            s.statusData[`ST_BLOCK_HI:`ST_BLOCK_LO];
        end
      end
    end

    // self-timed internal write, unaffected by the pin
    if (s.busy) begin
      next_s.busyCnt = s.busyCnt + 32'h1;
      if (s.busyArray && s.busyCnt < 32'(`PAGE_BYTES)) begin
        idx = s.busyCnt[4:0];
        wa = {s.pageBase, idx};
        if (s.pageValid[idx] && !isProtected(wa, s.blockProtect)) begin
          next_s.arrWr.en = 1'h1;
          next_s.arrWr.addr = wa;
          next_s.arrWr.data = s.pageBuf[idx];
        end
      end
      if (lastCycle) begin
        next_s.busy = 1'h0;
        next_s.busyArray = 1'h0;
        next_s.latch = 1'h0;
        next_s.pageValid = '0;
      end
    end

    next_s.statusOut = {next_s.protectPinEn, 3'h0, next_s.blockProtect,
                        next_s.latch, next_s.busy};
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s <= '0;
      s.csnS1 <= 1'h1;
      s.csnS2 <= 1'h1;
      s.csnQ <= 1'h1;
      s.wpS1 <= 1'h1;
      s.wpS2 <= 1'h1;
      s.phase <= PH_IDLE;
      s.latch <= 1'h0;
      s.protectPinEn <= `PROTECT_PIN_EN_RST;
      s.blockProtect <= `BLOCK_PROTECT_RST;
      s.statusOut <= {`PROTECT_PIN_EN_RST, 3'h0, `BLOCK_PROTECT_RST, 2'h0};
    end else begin
      s <= next_s;
    end
  end

  assign so = linkOut.so;
  assign soOe = s.soOe;
  assign arrWr = s.arrWr;
  assign statusReg = s.statusOut;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  chk_latch_set_rise: assert property (
    csRise && s.armed && !s.busy && aligned && s.opcode == `OP_SET_LATCH
    && s.nBytes == 6'h01 |=> s.latch ##0 statusReg[`ST_LATCH])
    else $error("latch not set after set command");

  chk_latch_no_chain: assert property (
    csRise && !s.latch && s.opcode == `OP_SET_LATCH && s.nBytes != 6'h01
    |=> !s.latch)
    else $error("latch set by chained frame");

  chk_page_wrap: assert property (
    byteEv && s.phase == PH_DATA && s.addr[4:0] == 5'h1F
    |=> s.addr[4:0] == 5'h00 && s.addr[11:5] == $past(s.addr[11:5]))
    else $error("page address did not wrap");

  chk_abort_partial: assert property (
    csRise && !aligned && !s.busy |=> !s.busy)
    else $error("write started on unaligned select rise");

  chk_latch_end: assert property (
    lastCycle |=> !s.busy && !statusReg[`ST_LATCH] && !statusReg[`ST_BUSY])
    else $error("latch or busy left set after write");

  chk_ignore_busy: assert property (
    s.busy && s.phase == PH_OPCODE && byteEv
    && linkOut.byteData != `OP_READ_STATUS |=> s.phase == PH_IGNORE)
    else $error("command accepted while busy");

  chk_read_status_oe: assert property (
    s.phase == PH_OPCODE && byteEv && linkOut.byteData == `OP_READ_STATUS
    && !csRise |=> soOe ##0 s.phase == PH_READ_STATUS)
    else $error("status read not enabled");

  chk_status_busy: assert property (
    $rose(s.busy) |-> ##1 statusReg[`ST_BUSY] [*3])
    else $error("busy flag not shown");

  chk_block_prot: assert property (
    arrWr.en |-> !isProtected(arrWr.addr, s.blockProtect))
    else $error("write to protected block");

  chk_hw_protect: assert property (
    csRise && s.protectPinEn && !s.wpS2 && s.opcode == `OP_WRITE_STATUS
    |=> $stable(s.blockProtect) && s.protectPinEn)
    else $error("status written while pin protected");

  chk_unarmed_idle: assert property (
    !s.armed |-> !soOe && !s.busy && !s.latch)
    else $error("active before first select fall");

  chk_latch_clear: assert property (
    csRise && s.armed && !s.busy && aligned && s.opcode == `OP_CLEAR_LATCH
    && s.nBytes == 6'h01 |=> !s.latch ##0 !statusReg[`ST_LATCH])
    else $error("latch not cleared after clear command");

  chk_status_layout: assert property (
    statusReg[6:4] == 3'h0 && statusReg[`ST_BUSY] == s.busy
    && statusReg[`ST_LATCH] == s.latch)
    else $error("status byte out of step");

  chk_burst_window: assert property (
    arrWr.en |-> s.busyArray && s.busyCnt <= 32'(`PAGE_BYTES))
    else $error("array write outside burst");

  chk_busy_holds: assert property (
    s.busy && !lastCycle |=> s.busy)
    else $error("internal write cut short");

  cov_array_write: cover property (s.busyArray && arrWr.en);
  cov_status_write: cover property ($rose(s.busy) && !s.busyArray);
  cov_read_busy: cover property (soOe && s.busy);
  cov_page_wrap: cover property (byteEv && s.phase == PH_DATA
    && s.addr[4:0] == 5'h1F);
  cov_pin_block: cover property (csRise && pinProtect
    && s.opcode == `OP_WRITE_STATUS);

endmodule // spi_eeprom_write_protect_ctrl

//--- hw/eeprom_wp_defs.svh
`ifndef EEPROM_WP_DEFS_SVH
`define EEPROM_WP_DEFS_SVH

// command opcodes
`define OP_WRITE_STATUS 8'h01
`define OP_ARRAY_WRITE 8'h02
`define OP_CLEAR_LATCH 8'h04
`define OP_READ_STATUS 8'h05
`define OP_SET_LATCH 8'h06

// status byte field positions
`define ST_PROTECT_PIN_EN 7
`define ST_BLOCK_HI 3
`define ST_BLOCK_LO 2
`define ST_LATCH 1
`define ST_BUSY 0

// nonvolatile status reset values
`define PROTECT_PIN_EN_RST 1'h0
`define BLOCK_PROTECT_RST 2'h0

// array geometry and protected ranges
`define PAGE_BYTES 32
`define ADDR_BITS 12
`define PROT_QUARTER_BASE 12'hC00
`define PROT_HALF_BASE 12'h800

// self-timed write
`define WRITE_TIME_NS 5000000
`define SYS_CLK_MHZ 250
`define WRITE_CYCLES ((`WRITE_TIME_NS * `SYS_CLK_MHZ) / 1000)

`endif

//--- hw/eeprom_wp_pkg.sv
package eeprom_wp_pkg;

  typedef enum logic [2:0] {
    PH_IDLE, PH_OPCODE, PH_ADDR_HI, PH_ADDR_LO, PH_DATA, PH_STATUS_DATA,
    PH_READ_STATUS, PH_IGNORE
  } phase_t;

  typedef struct packed {
    logic [6:0] shift;
    logic [2:0] bitCnt;
  } link_shift_t;

  typedef struct packed {
    logic byteTgl;
    logic [7:0] byteData;
    logic partial;
    logic so;
  } link_out_t;

  typedef struct packed {
    logic en;
    logic [11:0] addr;
    logic [7:0] data;
  } array_wr_t;

  typedef struct packed {
    logic csnS1, csnS2, csnQ;
    logic tglS1, tglS2, tglQ;
    logic partS1, partS2;
    logic wpS1, wpS2;
    logic armed;
    phase_t phase;
    logic [7:0] opcode;
    logic [5:0] nBytes;
    logic [11:0] addr;
    logic hasData;
    logic [7:0] statusData;
    logic [31:0][7:0] pageBuf;
    logic [31:0] pageValid;
    logic [6:0] pageBase;
    logic busy;
    logic busyArray;
    logic [31:0] busyCnt;
    logic latch;
    logic protectPinEn;
    logic [1:0] blockProtect;
    logic [7:0] statusOut;
    logic soOe;
    array_wr_t arrWr;
  } ctrl_state_t;

endpackage

//--- tb/spi_host_model.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// host side of the serial link, clock only runs inside frames
module spi_host_model (
  output logic sck,
  output logic csN,
  output logic si,
  input wire logic so
);
  logic [7:0] rxByte;
  initial begin
    sck = 1'b0;
    csN = 1'b1;
    si = 1'b0;
    rxByte = 8'h00;
  end
  always @(posedge sck) begin
    rxByte <= {rxByte[6:0], so};
  end
  // bytes msb first, then extra zero bits for a broken frame
  task automatic frame(input logic [7:0] q[$], input int extra);
    csN = 1'b0;
    #80;
    for (int i = 0; i < q.size() * 8 + extra; i++) begin
      si = (i / 8 < q.size()) ? q[i / 8][7 - i % 8] : 1'b0;
      #80 sck = 1'b1;
      #80 sck = 1'b0;
    end
    #80 csN = 1'b1;
    si = ~si;
    #200;
  endtask
endmodule // spi_host_model

//--- tb/spi_eeprom_write_protect_ctrl_test.sv
`timescale 1ns/10ps
module spi_eeprom_write_protect_ctrl_test;
  import eeprom_wp_pkg::*;
  localparam int WR = 3000;
  logic sys_clk = 1'b0;
  logic rst;
  logic wpN = 1'b1;
  logic sck, csN, si, so, soOe;
  array_wr_t arrWr;
  logic [7:0] statusReg;
  int failures = 0;
  int checksDone = 0;
  int cycles = 0;
  int busyRun = 0;
  int lastBusy = 0;
  int oeCycles = 0;
  logic [19:0] wrLog[$];
  logic [19:0] exp[$];
  logic [15:0] prot[5];
  logic [4:0] protOk;

  always #2 sys_clk = ~sys_clk;

  spi_eeprom_write_protect_ctrl #(.WR_CYCLES(WR))
    u_spi_eeprom_write_protect_ctrl (.sys_clk(sys_clk), .rst(rst),
    .sck(sck), .csN(csN), .si(si), .wpN(wpN), .so(so), .soOe(soOe),
    .arrWr(arrWr), .statusReg(statusReg));
  spi_host_model u_spi_host_model (.sck(sck), .csN(csN), .si(si),
    .so(so));

  //////////////////////////////////////////////////////////////////////////////
  // monitors and watchdog
  always @(posedge sys_clk) begin
    if (arrWr.en === 1'b1) wrLog.push_back({arrWr.addr, arrWr.data});
    if (soOe === 1'b1) oeCycles++;
    if (statusReg[0] === 1'b1) busyRun++;
    else if (busyRun != 0) begin
      lastBusy = busyRun;
      busyRun = 0;
    end
    cycles++;
    if (cycles == 90000) begin
      failures++;
      $display("unexpected at %0t: run too long", $time);
      test_done();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic check(input logic ok, input string msg);
    checksDone++;
    if (ok !== 1'b1) begin
      failures++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  task automatic send(input logic [7:0] q[$], input int extra);
    u_spi_host_model.frame(q, extra);
    repeat (8) @(posedge sys_clk);
  endtask
  task automatic waitIdle();
    int n;
    n = 0;
    while (statusReg[0] !== 1'b0 && n < WR + 50) begin
      @(posedge sys_clk);
      n++;
    end
    check(n < WR + 50, "busy stuck");
  endtask
  task automatic statusWrite(input logic [7:0] v);
    send('{8'h06}, 0);
    send('{8'h01, v}, 0);
    waitIdle();
  endtask
  task automatic arrayWrite(input logic [11:0] a, input int extra);
    send('{8'h06}, 0);
    send('{8'h02, {4'hF, a[11:8]}, a[7:0], 8'hA5}, extra);
    waitIdle();
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    check(statusReg === 8'h00 && soOe === 1'b0, "reset state");
    check(arrWr.en === 1'b0, "write at reset");
  endtask
  task automatic t_latch();
    send('{8'h06}, 0);
    check(statusReg === 8'h02, "latch not set");
    send('{8'h04}, 0);
    check(statusReg === 8'h00, "latch not cleared");
    send('{8'h06, 8'h02, 8'h00, 8'h10, 8'h55}, 0);
    waitIdle();
    check(wrLog.size() == 0 && statusReg === 8'h00, "unframed");
    check(oeCycles == 0, "output enabled on write frame");
  endtask
  task automatic t_page();
    int n;
    n = 0;
    send('{8'h06}, 0);
    send('{8'h02, 8'hF0, 8'h1E, 8'h11, 8'h22, 8'h33, 8'h44}, 0);
    while (statusReg[0] !== 1'b1 && n < 20) begin
      @(posedge sys_clk);
      n++;
    end
    n = oeCycles;
    send('{8'h05, 8'h00}, 0);
    check(u_spi_host_model.rxByte === 8'h03, "busy status");
    check(oeCycles - n > 300 && soOe === 1'b0, "read enable");
    send('{8'h02, 8'h00, 8'h40, 8'h77}, 0);
    waitIdle();
    exp = '{20'h00033, 20'h00144, 20'h01E11, 20'h01F22};
    check(wrLog.size() == 4, "page byte count");
    foreach (exp[i]) check(wrLog[i] === exp[i], "page wrap");
    check(statusReg === 8'h00, "latch after write");
    @(posedge sys_clk);
    check(lastBusy >= WR - 3 && lastBusy <= WR + 3, "busy length");
  endtask
  task automatic t_abort();
    wrLog.delete();
    arrayWrite(12'h100, 3);
    check(wrLog.size() == 0 && statusReg === 8'h02, "unaligned end");
    send('{8'h04}, 0);
  endtask
  task automatic t_protect();
    prot = '{16'h1BFF, 16'h1C00, 16'h27FF, 16'h2800, 16'h3000};
    protOk = 5'b10100;
    foreach (prot[i]) begin
      statusWrite({4'h0, prot[i][13:12], 2'b00});
      check(statusReg[3:2] === prot[i][13:12], "block code");
      wrLog.delete();
      arrayWrite(prot[i][11:0], 0);
      check(wrLog.size() == (protOk[4 - i] ? 1 : 0), "range");
    end
    statusWrite(8'h00);
  endtask
  task automatic t_pin();
    statusWrite(8'h80);
    check(statusReg === 8'h80, "pin enable set");
    wpN <= 1'b0;
    statusWrite(8'h8C);
    check(statusReg === 8'h82, "status not protected");
    wrLog.delete();
    arrayWrite(12'h123, 0);
    check(wrLog.size() == 1 && wrLog[0] === 20'h123A5, "array");
    wpN <= 1'b1;
    statusWrite(8'h00);
    check(statusReg === 8'h00, "pin release");
  endtask
  task automatic t_rearm();
    send('{8'h06}, 0);
    rst <= 1'b1;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (5) @(posedge sys_clk);
    check(statusReg === 8'h00 && soOe === 1'b0, "mid reset");
    send('{8'h06}, 0);
    check(statusReg === 8'h02, "latch after reset");
    send('{8'h04}, 0);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // closing report
  task automatic test_done();
    $display("checks %0d failures %0d", checksDone, failures);
    if (failures == 0 && checksDone > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    rst <= 1'b1;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (5) @(posedge sys_clk);
    t_reset();
    t_latch();
    t_page();
    t_abort();
    t_protect();
    t_pin();
    t_rearm();
    test_done();
  end
endmodule // spi_eeprom_write_protect_ctrl_test
